// >>> hw/ept_timer.sv
// Eight-bit period timer with prescaler, postscaler and interrupt
`include "ept_consts.svh"

module ept_timer #(
  parameter int COUNT_W = 8,
  parameter int PRE_W = 4,
  parameter int POST_W = 4
) (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic [3:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  output logic O_IRQ,
  output ept_pkg::ept_events_t O_EVENTS
);
  import ept_pkg::*;

  // ========================================================
  // Elaboration checks
  // The logic is written for the documented widths only
  if (COUNT_W != 8) begin : g_count_w
    $error("count width must be 8");
  end
  if (PRE_W != 4) begin : g_pre_w
    $error("prescale width must be 4");
  end
  if (POST_W != 4) begin : g_post_w
    $error("postscale width must be 4");
  end

  // ========================================================
  // Bus decode
  ept_bus_req_t req;
  assign req = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};

  // Write strobe qualified by one register address
  function automatic logic wr_hit(input ept_bus_req_t r,
                                  input logic [3:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction : wr_hit

  wire logic wr_ctrl = wr_hit(req, `EPT_ADDR_CONTROL);
  wire logic wr_count = wr_hit(req, `EPT_ADDR_COUNT);
  wire logic wr_period = wr_hit(req, `EPT_ADDR_PERIOD);
  wire logic wr_en = wr_hit(req, `EPT_ADDR_IRQ_ENABLES);
  wire logic wr_clr = wr_hit(req, `EPT_ADDR_IRQ_CLEAR);

  // ========================================================
  // Registers
  logic [7:0] control_reg;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [7:0] period_reg;
  logic [7:0] flags_reg;
  logic [7:0] enables_reg;
  logic [1:0] instr_div_reg;
  logic [3:0] pre_cnt_reg;
  logic [3:0] pre_cnt_next;
  logic [3:0] post_cnt_reg;
  logic [3:0] post_cnt_next;
  logic restart_pend_reg;
  logic [7:0] rdata_reg;
  logic irq_reg;
  logic match_reg;
  logic restart_reg;
  logic shift_reg;

  // ========================================================
  // Field views
  wire ept_prescale_t pre_sel =
    ept_prescale_t'(control_reg[`EPT_CTRL_PRE_LSB +: 2]);
  wire logic [3:0] post_sel = control_reg[`EPT_CTRL_POST_LSB +: 4];
  wire logic run = control_reg[`EPT_CTRL_RUN_BIT];

  // Prescale terminal count by select code
  function automatic logic [3:0] pre_last(input ept_prescale_t sel);
    case (sel)
      EPT_PRE_DIV1: pre_last = 4'h0;
      EPT_PRE_DIV4: pre_last = `EPT_PRE_DIV4_LAST;
      default: pre_last = `EPT_PRE_DIV16_LAST;
    endcase
  endfunction : pre_last

  // ========================================================
  // Tick chain
  // Instruction tick: free-running divide by four of the system clock
  wire logic instr_tick = (instr_div_reg == `EPT_INSTR_DIV);
  wire logic pre_wrap = (pre_cnt_reg >= pre_last(pre_sel));
  wire logic timer_tick = run && instr_tick && pre_wrap;
  wire logic scaler_clr = wr_count || wr_ctrl;

  // Compared every cycle, so a period write hits immediately
  wire logic match = (count_reg == period_reg);
  wire logic match_tick = timer_tick && match;
  wire logic post_hit = match_tick && (post_cnt_reg == post_sel);

  always_comb begin
    pre_cnt_next = pre_cnt_reg;
    if (scaler_clr) begin
      pre_cnt_next = 4'h0;
    end else if (run && instr_tick) begin
      pre_cnt_next = pre_wrap ? 4'h0 : pre_cnt_reg + 4'h1;
    end
  end

  always_comb begin
    post_cnt_next = post_cnt_reg;
    if (scaler_clr) begin
      post_cnt_next = 4'h0;
    end else if (post_hit) begin
      post_cnt_next = 4'h0;
    end else if (match_tick) begin
      post_cnt_next = post_cnt_reg + 4'h1;
    end
  end

  // Software count write wins over the hardware step
  always_comb begin
    count_next = count_reg;
    if (wr_count) begin
      count_next = req.wdata;
    end else if (match_tick) begin
      count_next = 8'h00;
    end else if (timer_tick) begin
      count_next = count_reg + 8'h01;
    end
  end

  // Flag set wins over a clear in the same cycle
  wire logic [7:0] flag_set = {6'h00, post_hit, 1'b0};
  wire logic [7:0] flag_clr = wr_clr ? req.wdata : 8'h00;
  wire logic [7:0] flags_next = (flags_reg & ~flag_clr) | flag_set;
  wire logic irq_next = |(flags_next & enables_reg);

  // ========================================================
  // Read mux
  logic [7:0] rd_mux;
  always_comb begin
    case (req.addr)
      `EPT_ADDR_CONTROL: rd_mux = control_reg;
      `EPT_ADDR_COUNT: rd_mux = count_reg;
      `EPT_ADDR_PERIOD: rd_mux = period_reg;
      `EPT_ADDR_IRQ_FLAGS: rd_mux = flags_reg;
      `EPT_ADDR_IRQ_ENABLES: rd_mux = enables_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  // ========================================================
  // Control and counting state
  // Free-running, so register writes never shift the tick phase
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      instr_div_reg <= 2'h0;
    end else begin
      instr_div_reg <= instr_div_reg + 2'h1;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      control_reg <= `EPT_CONTROL_RESET;
    end else begin
      if (wr_ctrl) begin
        control_reg <= req.wdata & `EPT_CTRL_WMASK;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      period_reg <= `EPT_PERIOD_RESET;
    end else begin
      if (wr_period) begin
        period_reg <= req.wdata;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      count_reg <= `EPT_COUNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  // Stopped timer keeps its prescale count; only writes clear it
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      pre_cnt_reg <= 4'h0;
    end else begin
      pre_cnt_reg <= pre_cnt_next;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      post_cnt_reg <= 4'h0;
    end else begin
      post_cnt_reg <= post_cnt_next;
    end
  end

  // ========================================================
  // Interrupt and read data
  // Set wins over clear, so no match is lost to a late clear
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      flags_reg <= 8'h00;
    end else begin
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      enables_reg <= 8'h00;
    end else begin
      if (wr_en) begin
        enables_reg <= req.wdata;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // Read data stands one cycle only, zero otherwise
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= req.rd ? rd_mux : 8'h00;
    end
  end

  // ========================================================
  // Event outputs
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      match_reg <= 1'b0;
    end else begin
      match_reg <= (count_next == period_reg);
    end
  end

  // Restart pulse held high across one full instruction cycle
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      restart_pend_reg <= 1'b0;
    end else if (match_tick) begin
      restart_pend_reg <= 1'b1;
    end else if (instr_tick) begin
      restart_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= restart_pend_reg;
    end
  end

  // Toggles once per restart, giving half the match rate
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      shift_reg <= 1'b0;
    end else begin
      if (match_tick) begin
        shift_reg <= ~shift_reg;
      end
    end
  end

  assign O_RDATA = rdata_reg;
  assign O_IRQ = irq_reg;
  assign O_EVENTS = '{match: match_reg, restart: restart_reg,
                      shift_clk: shift_reg};

endmodule : ept_timer

// >>> include/ept_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef EPT_CONSTS_SVH
`define EPT_CONSTS_SVH

// ==========================================================
// Register offsets
`define EPT_ADDR_CONTROL 4'h0
`define EPT_ADDR_COUNT 4'h1
`define EPT_ADDR_PERIOD 4'h2
`define EPT_ADDR_IRQ_FLAGS 4'h3
`define EPT_ADDR_IRQ_ENABLES 4'h4
`define EPT_ADDR_IRQ_CLEAR 4'h5

// ==========================================================
// Field positions
`define EPT_CTRL_PRE_LSB 0
`define EPT_CTRL_RUN_BIT 2
`define EPT_CTRL_POST_LSB 3
`define EPT_IRQ_MATCH_BIT 1

// ==========================================================
// Reset values and divider figures
`define EPT_CONTROL_RESET 8'h00
`define EPT_COUNT_RESET 8'h00
`define EPT_PERIOD_RESET 8'hFF
`define EPT_CTRL_WMASK 8'h7F
`define EPT_INSTR_DIV 2'h3
`define EPT_PRE_DIV4_LAST 4'h3
`define EPT_PRE_DIV16_LAST 4'hF

`endif

// >>> include/ept_pkg.sv
// Types shared by the eight-bit period timer
package ept_pkg;

  // ========================================================
  // Register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ept_bus_req_t;

  // ========================================================
  // Timer event outputs
  typedef struct packed {
    logic match;
    logic restart;
    logic shift_clk;
  } ept_events_t;

  // ========================================================
  // Prescale select codes
  typedef enum logic [1:0] {
    EPT_PRE_DIV1 = 2'b00,
    EPT_PRE_DIV4 = 2'b01,
    EPT_PRE_DIV16A = 2'b10,
    EPT_PRE_DIV16B = 2'b11
  } ept_prescale_t;

endpackage : ept_pkg

// >>> tb/ept_timer_sva.sv
// Port-level assertions for the period timer
`include "ept_consts.svh"
module ept_checker (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic [3:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] O_RDATA,
  input wire logic O_IRQ,
  input wire ept_pkg::ept_events_t O_EVENTS
);
  import ept_pkg::*;
  // ==========================================================
  // Checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
    else $error("read data not zero");
  a_period_back: assert property (I_WR &&
    I_ADDR == `EPT_ADDR_PERIOD ##1 I_RD && I_ADDR == `EPT_ADDR_PERIOD
    |=> O_RDATA == $past(I_WDATA, 2))
    else $error("period readback wrong");
  a_restart_width: assert property ($rose(O_EVENTS.restart) |->
    O_EVENTS.restart[*4] ##1 !O_EVENTS.restart) else $error("restart width");
  a_restart_cause: assert property ($rose(O_EVENTS.restart) |->
    $past(O_EVENTS.match, 2)) else $error("restart without match");
  a_shift_step: assert property ($changed(O_EVENTS.shift_clk) |=>
    $rose(O_EVENTS.restart)) else $error("shift clock off restart");
  a_irq_masked: assert property (I_WR &&
    I_ADDR == `EPT_ADDR_IRQ_ENABLES && !I_WDATA[1] |-> ##2 !O_IRQ)
    else $error("masked irq high");
  a_flag_bits: assert property ($past(I_RD) &&
    $past(I_ADDR) == `EPT_ADDR_IRQ_FLAGS |-> O_RDATA[7:2] == 6'h00
    && !O_RDATA[0]) else $error("flag register bits");
  a_ctrl_top: assert property ($past(I_RD) &&
    $past(I_ADDR) == `EPT_ADDR_CONTROL |-> !O_RDATA[7])
    else $error("control bit 7 set");
  a_dead_reads: assert property ($past(I_RD) &&
    $past(I_ADDR) >= `EPT_ADDR_IRQ_CLEAR |-> O_RDATA == 8'h00)
    else $error("dead address read");
endmodule : ept_checker

bind ept_timer ept_checker chk_u (.I_CLK(I_CLK), .I_NRST(I_NRST),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
  .O_RDATA(O_RDATA), .O_IRQ(O_IRQ), .O_EVENTS(O_EVENTS));

// >>> tb/eight_bit_period_timer_test.sv
// Self-checking bench for the eight-bit period timer
`include "ept_consts.svh"
module eight_bit_period_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ept_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic irq;
  ept_events_t ev;
  int num_errors = 0, cmp_count = 0, cyc = 0, n, k, p;
  logic [3:0] q;
  logic [7:0] v;
  ept_timer dut_u (.I_CLK(clk), .I_NRST(rst_n), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_IRQ(irq),
    .O_EVENTS(ev));
  // ==========================================================
  // Clock, watchdog, helpers
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  function automatic int div(logic [1:0] c);
    return c[1] ? 16 : (c[0] ? 4 : 1);
  endfunction : div
  task automatic bus(logic w, logic [3:0] a, logic [7:0] d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask : bus
  task automatic idle();
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : idle
  // Samples just after the edge, so it sees the answer cycle
  task automatic rd_reg(logic [3:0] a, logic [7:0] e, string what);
    bus(1'b0, a, 8'h00);
    idle();
    chk(what, {8'h00, rdata}, {8'h00, e});
  endtask : rd_reg
  task automatic rise(output int m);
    logic b;
    m = 0;
    repeat (2000) begin
      b = ev.restart;
      @(posedge clk);
      m++;
      if (ev.restart === 1'b1 && b === 1'b0) return;
    end
  endtask : rise
  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(32'hbca0_2c5f));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(`EPT_ADDR_COUNT, 8'h00, "count");
    rd_reg(`EPT_ADDR_PERIOD, 8'hff, "period");
    rd_reg(`EPT_ADDR_IRQ_FLAGS, 8'h00, "flags");
    bus(1'b1, 4'hc, 8'hff);
    rd_reg(4'hc, 8'h00, "unmapped");
    // Timer always stopped before reconfiguring, avoiding odd restarts
    for (int c = 0; c < 4; c++) begin
      p = (c == 0) ? 1 : $urandom_range(3, 1);
      bus(1'b1, `EPT_ADDR_CONTROL, 8'h00);
      bus(1'b1, `EPT_ADDR_COUNT, 8'h00);
      bus(1'b1, `EPT_ADDR_PERIOD, p[7:0]);
      rd_reg(`EPT_ADDR_PERIOD, p[7:0], "period");
      bus(1'b1, `EPT_ADDR_CONTROL, 8'h04 | c[7:0]);
      idle();
      rise(n);
      rise(n);
      chk("interval", n[15:0], 16'((p + 1) * 4 * div(c[1:0])));
    end
    for (int i = 0; i < 3; i++) begin
      q = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($urandom_range(14, 1));
      bus(1'b1, `EPT_ADDR_CONTROL, 8'h00);
      bus(1'b1, `EPT_ADDR_PERIOD, 8'h00);
      bus(1'b1, `EPT_ADDR_COUNT, 8'h00);
      bus(1'b1, `EPT_ADDR_IRQ_ENABLES, 8'h02);
      bus(1'b1, `EPT_ADDR_IRQ_CLEAR, 8'h02);
      bus(1'b1, `EPT_ADDR_CONTROL, {1'b0, q, 3'h5});
      idle();
      k = 0;
      do begin
        rise(n);
        k++;
        @(posedge clk);
      end while (irq !== 1'b1 && k < 20);
      chk("matches", k[15:0], {12'h000, q} + 16'h0001);
    end
    bus(1'b1, `EPT_ADDR_CONTROL, 8'h00);
    bus(1'b1, `EPT_ADDR_IRQ_ENABLES, 8'h00);
    repeat (3) idle();
    chk("masked irq", {15'h0000, irq}, 16'h0000);
    bus(1'b1, `EPT_ADDR_IRQ_ENABLES, 8'h02);
    rd_reg(`EPT_ADDR_IRQ_FLAGS, 8'h02, "flags");
    chk("sticky irq", {15'h0000, irq}, 16'h0001);
    bus(1'b1, `EPT_ADDR_IRQ_CLEAR, 8'h02);
    repeat (3) idle();
    chk("cleared irq", {15'h0000, irq}, 16'h0000);
    v = 8'($urandom);
    p = $urandom_range(255, 0) & 32'h0000_00fb;
    bus(1'b1, `EPT_ADDR_COUNT, v);
    bus(1'b1, `EPT_ADDR_CONTROL, p[7:0]);
    rd_reg(`EPT_ADDR_CONTROL, p[7:0] & 8'h7f, "control");
    repeat (20) idle();
    rd_reg(`EPT_ADDR_COUNT, v, "held count");
    conclude();
  end
endmodule : eight_bit_period_timer_test
